// ===== common/touch_sense_pkg.sv
`default_nettype none
package touch_sense_pkg;
  // ---------------------------------------------------------------
  // register byte addresses (wishbone, one word each)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_PRIMARY   = 4'h0;
  localparam logic [3:0] ADDR_CHANNEL   = 4'h4;
  localparam logic [3:0] ADDR_TIMERS    = 4'h8;
  localparam logic [3:0] ADDR_COUNTS    = 4'hC;

  // ---------------------------------------------------------------
  // primary control fields
  // ---------------------------------------------------------------
  localparam int BIT_ENABLE   = 7;
  localparam int BIT_REFMODE  = 6;
  localparam int RNG_HI       = 3;
  localparam int RNG_LO       = 2;
  localparam int BIT_DIR      = 1;
  localparam int BIT_EXTSRC   = 0;

  // ---------------------------------------------------------------
  // channel and timer control fields
  // ---------------------------------------------------------------
  localparam int CH_W             = 4;
  localparam int NUM_CH           = 12;
  localparam logic [3:0] CH_RSVD_FIRST = 4'hC;
  localparam int BIT_T1_ON        = 0;
  localparam int BIT_T1_GE        = 1;
  localparam int T1CS_LO          = 2;
  localparam int T1CS_HI          = 3;
  localparam int BIT_T0_CS        = 4;
  localparam logic [1:0] T1CS_SENSE = 2'h3;
  localparam logic [1:0] RNG_OFF    = 2'h0;

  localparam logic [7:0]  PRIMARY_RST = 8'h00;
  localparam logic [31:0] DATA_ZERO   = 32'h0000_0000;

  typedef enum logic [1:0] {RANGE_OFF, RANGE_LOW, RANGE_MED, RANGE_HIGH} range_type;
endpackage
`default_nettype wire

// ===== logic/touch_sense_ctrl.sv
// Function
// - channel select field addresses up to twelve sense inputs.
// - enabled unit connects the oscillator to the chosen pin.
// - read-only flag shows oscillator sourcing or sinking.
// - oscillator can clock first timer or gated timer.
// - reference mode picks converter/fixed or ground/supply thresholds.
// - two-bit range code picks off/low/medium/high current.
// - variable mode code 00 is noise detection, charge source off.
// - noise on pin toggles comparator, seen as counts.
// - gated timer off, free running, or gated by on and enable.
// - enable bit powers unit; disabled means no channel connected.
// - channel codes 1100 to 1111 reserved, connect nothing.
// - external source bit picks oscillator or external clock pin.
`default_nettype none
module touch_sense_ctrl
  import touch_sense_pkg::*;
(
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // wishbone slave
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [3:0]          adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output logic      [31:0]         dat_o,
  output logic                     ack_o,
  // analog front end
  input  wire logic                osc_i,
  input  wire logic                ext_clk_i,
  input  wire logic                gate_i,
  output logic      [NUM_CH-1:0]   pad_connect_o,
  output logic                     charge_enable_o,
  output logic                     osc_enable_o,
  output logic      [1:0]          current_range_o,
  output logic                     ref_variable_o,
  // timer clock enables
  output logic                     first_timer_tick_o,
  output logic                     gated_timer_tick_o
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]        primary_ff;
  logic [CH_W-1:0]   channel_ff;
  logic [4:0]        timers_ff;
  logic [7:0]        first_count_ff;
  logic [15:0]       gated_count_ff;
  logic              ack_ff;
  logic [31:0]       dat_ff;
  logic [2:0]        osc_sync_ff;
  logic [2:0]        ext_sync_ff;
  logic [2:0]        gate_sync_ff;
  logic              osc_level_ff;
  logic              ext_level_ff;
  logic              gate_level_ff;
  logic              osc_rise;
  logic              ext_rise;
  logic              wr_req;
  logic              sense_on;

  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] nw, input logic en);
    merge8 = en ? nw : old;
  endfunction

  assign wr_req   = cyc_i && stb_i && we_i && !ack_ff;
  assign sense_on = primary_ff[BIT_ENABLE];

  // ---------------------------------------------------------------
  // bus writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      primary_ff <= PRIMARY_RST;
      channel_ff <= '0;
      timers_ff  <= '0;
    end else if (wr_req && sel_i[0]) begin
      unique case (adr_i)
        ADDR_PRIMARY: primary_ff <= {dat_i[7:6], 2'h0, dat_i[3:2], 1'b0, dat_i[0]};
        ADDR_CHANNEL: channel_ff <= dat_i[CH_W-1:0];
        ADDR_TIMERS:  timers_ff  <= dat_i[4:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // bus answer: one registered ack a cycle after the strobe, dropped the next cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= DATA_ZERO;
    end else begin
      ack_ff <= cyc_i && stb_i && !ack_ff;
      if (cyc_i && stb_i && !ack_ff) begin
        unique case (adr_i)
          ADDR_PRIMARY: dat_ff <= {24'h0, primary_ff[7:2], osc_level_ff, primary_ff[0]};
          ADDR_CHANNEL: dat_ff <= {28'h0, channel_ff};
          ADDR_TIMERS:  dat_ff <= {27'h0, timers_ff};
          ADDR_COUNTS:  dat_ff <= {gated_count_ff, 8'h0, first_count_ff};
          default:      dat_ff <= DATA_ZERO;
        endcase
      end
    end
  end
  assign ack_o = ack_ff;
  assign dat_o = dat_ff;

  // ---------------------------------------------------------------
  // pin synchronisers: level changes once stages two and three agree
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_sync_ff   <= '0;
      ext_sync_ff   <= '0;
      gate_sync_ff  <= '0;
      osc_level_ff  <= 1'b0;
      ext_level_ff  <= 1'b0;
      gate_level_ff <= 1'b0;
    end else begin
      osc_sync_ff  <= {osc_sync_ff[1:0], osc_i};
      ext_sync_ff  <= {ext_sync_ff[1:0], ext_clk_i};
      gate_sync_ff <= {gate_sync_ff[1:0], gate_i};
      if (osc_sync_ff[1] == osc_sync_ff[2]) begin
        osc_level_ff <= osc_sync_ff[2];
      end
      if (ext_sync_ff[1] == ext_sync_ff[2]) begin
        ext_level_ff <= ext_sync_ff[2];
      end
      if (gate_sync_ff[1] == gate_sync_ff[2]) begin
        gate_level_ff <= gate_sync_ff[2];
      end
    end
  end

  assign osc_rise = (osc_sync_ff[1] == osc_sync_ff[2]) && osc_sync_ff[2] && !osc_level_ff;
  assign ext_rise = (ext_sync_ff[1] == ext_sync_ff[2]) && ext_sync_ff[2] && !ext_level_ff;

  // ---------------------------------------------------------------
  // analog mux and oscillator controls
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_connect_o   <= '0;
      charge_enable_o <= 1'b0;
      osc_enable_o    <= 1'b0;
      current_range_o <= RNG_OFF;
      ref_variable_o  <= 1'b0;
    end else begin
      pad_connect_o <= '0;
      if (sense_on && channel_ff < CH_RSVD_FIRST) begin
        pad_connect_o[channel_ff] <= 1'b1;
      end
      ref_variable_o  <= primary_ff[BIT_REFMODE];
      current_range_o <= primary_ff[RNG_HI:RNG_LO];
      osc_enable_o    <= sense_on && (primary_ff[BIT_REFMODE] || primary_ff[RNG_HI:RNG_LO] != RNG_OFF);
      // noise mode: comparator alive, no charge current
      charge_enable_o <= sense_on && primary_ff[RNG_HI:RNG_LO] != RNG_OFF;
    end
  end

  // ---------------------------------------------------------------
  // timer clock routing and counters
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_timer_tick_o <= 1'b0;
      gated_timer_tick_o <= 1'b0;
    end else begin
      // first timer source
      // source bit set means internal core clock, which is not counted here
      first_timer_tick_o <= !timers_ff[BIT_T0_CS] && (primary_ff[BIT_EXTSRC] ? osc_rise : ext_rise);
      gated_timer_tick_o <= timers_ff[BIT_T1_ON] && (!timers_ff[BIT_T1_GE] || gate_level_ff)
                            && timers_ff[T1CS_HI:T1CS_LO] == T1CS_SENSE && osc_rise;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_count_ff <= '0;
    end else if (wr_req && adr_i == ADDR_COUNTS && sel_i[0]) begin
      first_count_ff <= merge8(first_count_ff, dat_i[7:0], 1'b1);
    end else if (first_timer_tick_o) begin
      first_count_ff <= first_count_ff + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gated_count_ff <= '0;
    end else if (wr_req && adr_i == ADDR_COUNTS && (sel_i[2] || sel_i[3])) begin
      gated_count_ff <= {merge8(gated_count_ff[15:8], dat_i[31:24], sel_i[3]),
                         merge8(gated_count_ff[7:0], dat_i[23:16], sel_i[2])};
    end else if (gated_timer_tick_o) begin
      gated_count_ff <= gated_count_ff + 16'h0001;
    end
  end

endmodule
`default_nettype wire

// ===== bench/touch_sense_ctrl_asserts.sv
`default_nettype none
module touch_sense_ctrl_asserts
  import touch_sense_pkg::*;
(
  // clock and reset
  input wire logic              clk_i,
  input wire logic              rst_i,
  // watched outputs and oscillator input
  input wire logic              ack_o,
  input wire logic              osc_i,
  input wire logic [NUM_CH-1:0] pad_connect_o,
  input wire logic              charge_enable_o,
  input wire logic              osc_enable_o,
  input wire logic [1:0]        current_range_o,
  input wire logic              ref_variable_o,
  input wire logic              gated_timer_tick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_pad_onehot: assert property ($onehot0(pad_connect_o)) else $error("two pads connected");
  a_noise_no_charge: assert property (ref_variable_o && current_range_o == RNG_OFF |-> !charge_enable_o)
    else $error("charge on in noise mode");
  a_noise_osc_on: assert property (ref_variable_o && current_range_o == RNG_OFF && |pad_connect_o
    |-> osc_enable_o) else $error("oscillator off in noise mode");
  a_fixed_off: assert property (!ref_variable_o && current_range_o == RNG_OFF
    |-> !osc_enable_o && !charge_enable_o) else $error("oscillator on in fixed off range");
  a_charge_range: assert property (charge_enable_o |-> osc_enable_o && current_range_o != RNG_OFF)
    else $error("charge without range");
  a_tick_single: assert property (gated_timer_tick_o |=> !gated_timer_tick_o) else $error("double tick");
  a_tick_needs_edge: assert property (!osc_i [*8] |=> !gated_timer_tick_o) else $error("tick without edge");
  a_quiet_reset: assert property ($fell(rst_i) |-> !ack_o && pad_connect_o == '0 && !osc_enable_o)
    else $error("outputs active after reset");
endmodule
bind touch_sense_ctrl touch_sense_ctrl_asserts chk_u (.clk_i, .rst_i, .ack_o, .osc_i, .pad_connect_o,
  .charge_enable_o, .osc_enable_o, .current_range_o, .ref_variable_o, .gated_timer_tick_o);
`default_nettype wire

// ===== bench/touch_pad_model.sv
`default_nettype none
module touch_pad_model (
  // clock and oscillator power
  input  wire logic clk_i,
  input  wire logic osc_enable_i,
  // pad conditions
  input  wire logic activity_i,
  input  wire logic touched_i,
  // comparator output
  output var  logic osc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int half_cnt;
  initial osc_o = 1'b0;
  initial half_cnt = 0;
  // pad taken as analog input with its own driver off
  always @(posedge clk_i) begin
    if (!osc_enable_i) begin
      osc_o <= 1'b0;
      half_cnt <= 0;
    end else if (activity_i && half_cnt >= (touched_i ? 5 : 3)) begin
      osc_o <= ~osc_o;
      half_cnt <= 0;
    end else if (activity_i) begin
      half_cnt <= half_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ===== bench/test_capacitive_touch_sense_control.sv
`default_nettype none
module test_capacitive_touch_sense_control
  import touch_sense_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_i, rst_i, cyc, stb, we, ack, act, touched, gate, osc, osc_en, chg_en, ref_var, e;
  logic [3:0]        adr, sel;
  logic [31:0]       wdat, rdat, q;
  logic [1:0]        rng;
  logic [NUM_CH-1:0] pads;
  int                fail_count, checks_done, rises, cycles;
  int                ext_rises, t_first, t_gated, exp_g, exp_f, ext_div;
  int                freq [2];
  logic              ext_clk = 1'b0;
  logic              ftick, gtick;
  touch_sense_ctrl dut_u (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .osc_i(osc), .ext_clk_i(ext_clk), .gate_i(gate),
    .pad_connect_o(pads), .charge_enable_o(chg_en), .osc_enable_o(osc_en), .current_range_o(rng),
    .ref_variable_o(ref_var), .first_timer_tick_o(ftick), .gated_timer_tick_o(gtick));
  touch_pad_model pad_u (.clk_i, .osc_enable_i(osc_en), .activity_i(act), .touched_i(touched), .osc_o(osc));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge osc) rises++;
  always @(posedge ext_clk) ext_rises++;
  // external clock pin toggles only inside a window, slower than the untouched pad and faster than the touched one
  always @(posedge clk_i) begin
    ext_div <= (ext_div == 4) ? 0 : ext_div + 1;
    if (act && ext_div == 4) ext_clk <= ~ext_clk;
  end
  always @(posedge clk_i) begin
    if (ftick) t_first++;
    if (gtick) t_gated++;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hF, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    check("ack wait", n, 32'h0000_0002);
    {cyc, stb} <= 2'b00;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    {cyc, stb, we, act, touched, gate, e, adr, sel, wdat} = '0;
    {fail_count, checks_done, rises, cycles} = '0;
    rst_i = 1'b1;
    void'($urandom(85));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, 4'h2, 32'hFFFF_FFFF);
    for (int a = 0; a < 16; a += 2) begin
      wb(1'b0, a[3:0], 32'h0);
      check("reset read", q, 32'h0);
    end
    wb(1'b1, ADDR_PRIMARY, 32'h7E);
    wb(1'b0, ADDR_PRIMARY, 32'h0);
    check("primary", q, 32'h4C);
    $display("registers done");
    for (int c = 0; c < 16; c++) begin
      e = 1'($urandom);
      wb(1'b1, ADDR_PRIMARY, {24'h0, e, 7'h0});
      wb(1'b1, ADDR_CHANNEL, c);
      repeat (3) @(negedge clk_i);
      check("pads", pads, (e && c < NUM_CH) ? 32'h1 << c : 32'h0);
    end
    $display("channels done");
    for (int m = 0; m < 8; m++) begin
      wb(1'b1, ADDR_PRIMARY, {24'h0, 1'b1, m[2], 2'b0, m[1:0], 2'b0});
      repeat (3) @(negedge clk_i);
      check("analog", {osc_en, chg_en, ref_var, rng}, {m[2] | (m[1:0] != 0), m[1:0] != 0, m[2], m[1:0]});
    end
    $display("analog done");
    for (int k = 0; k < 16; k++) begin
      gate <= 1'($urandom); // gate level stands in for the software window
      touched <= 1'($urandom);
      e = 1'($urandom);
      wb(1'b1, ADDR_PRIMARY, {24'h0, k[2] ? 8'hC0 : 8'h8C} | {31'h0, !k[3]});
      wb(1'b1, ADDR_CHANNEL, $urandom % NUM_CH);
      wb(1'b1, ADDR_TIMERS, {27'h0, e, T1CS_SENSE, k[1], k[0]});
      repeat (12) @(posedge clk_i);
      wb(1'b1, ADDR_COUNTS, 32'h0);
      {rises, ext_rises, t_first, t_gated} = '0;
      act <= 1'b1;
      repeat (60 + $urandom % 40) @(posedge clk_i);
      act <= 1'b0;
      repeat (12) @(posedge clk_i);
      wb(1'b0, ADDR_COUNTS, 32'h0);
      exp_g = (k[0] && (!k[1] || gate)) ? rises : 0;
      exp_f = e ? 0 : (k[3] ? ext_rises : rises) % 256;
      check("gated count", q[31:16], exp_g);
      check("gated ticks", t_gated, exp_g);
      check("first count", q[7:0], exp_f);
      check("first ticks", t_first, exp_f);
      wb(1'b0, ADDR_PRIMARY, 32'h0);
      check("direction", q[1], osc);
    end
    $display("counting done");
    wb(1'b1, ADDR_PRIMARY, 32'h8D);
    wb(1'b1, ADDR_TIMERS, {27'h0, 1'b0, T1CS_SENSE, 1'b0, 1'b1});
    for (int t = 0; t < 2; t++) begin
      touched <= t[0];
      wb(1'b1, ADDR_COUNTS, 32'h0);
      rises = 0;
      act <= 1'b1;
      repeat (96) @(posedge clk_i);
      act <= 1'b0;
      repeat (12) @(posedge clk_i);
      wb(1'b0, ADDR_COUNTS, 32'h0);
      check("window count", q[31:16], rises);
      freq[t] = q[31:16];
    end
    // same window, so the loaded pad must give fewer counts
    check("loaded slower", freq[1] < freq[0], 1'b1);
    $display("window done");
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADDR_PRIMARY, 32'h0);
    check("second reset", q, 32'h0);
    $display("reset done");
    close_out();
  end
endmodule
`default_nettype wire
